// ---- core/thr_comparator.sv ----
// analog threshold comparator with single-input and difference modes, APB registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// - analog input 0..10 V is integer 0..1000
// - signed gain in hundredths, magnitude at most 10
// - signed offset up to 10000, added after gain
// - thresholds and delta limited to 20000 magnitude
// - single mode: actual value is input*gain+offset
// - single mode: clear threshold is set plus delta
// - negative delta: above set sets, at or below clear clears
// - positive delta: high only inside set..clear window
// - difference mode scales both inputs identically
// - difference operand is first minus second scaled
// - set at or above clear: hysteresis on difference
// - set below clear: window test on difference
// - decimal places never affect the comparison
// - difference thresholds may come from other blocks
module thr_comparator #(
	parameter int NBLK = 8
) (
	input  wire logic                                  mclk_in,
	input  wire logic                                  rstn_in,
	input  wire logic                                  psel_in,
	input  wire logic                                  penable_in,
	input  wire logic                                  pwrite_in,
	input  wire logic [thr_cmp_pkg::ADDR_W-1:0]        paddr_in,
	input  wire logic [thr_cmp_pkg::DATA_W-1:0]        pwdata_in,
	output logic      [thr_cmp_pkg::DATA_W-1:0]        prdata_out,
	output logic                                       pready_out,
	output logic                                       pslverr_out,
	input  wire logic                                  cycle_tick_in,
	input  wire logic [thr_cmp_pkg::RAW_W-1:0]         first_analog_input_in,
	input  wire logic [thr_cmp_pkg::RAW_W-1:0]         second_analog_input_in,
	input  wire logic [NBLK*thr_cmp_pkg::DATA_W-1:0]   block_values_in,
	output logic                                       switch_out,
	output logic      [thr_cmp_pkg::DATA_W-1:0]        actual_value_out
);
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic signed [31:0] blk_pick(input logic [NBLK*32-1:0] vec,
	                                                  input logic [thr_cmp_pkg::BLK_SEL_W-1:0] idx);
		if (int'(idx) < NBLK)
			return $signed(vec[int'(idx)*32 +: 32]);
		else
			return thr_cmp_pkg::ZERO_32;
	endfunction : blk_pick

	// ************************************************************
	// declarations
	// ************************************************************
	logic        [thr_cmp_pkg::CTRL_W-1:0]    ctrl_r;
	logic signed [31:0]                       gain_r;
	logic signed [31:0]                       offset_r;
	logic signed [31:0]                       on_r;
	logic signed [31:0]                       off_r;
	logic        [2*thr_cmp_pkg::BLK_SEL_W-1:0] blksel_r;
	logic        [31:0]                       prdata_r;
	logic                                     pslverr_r;
	logic                                     q_r;
	logic                                     q_nxt;
	logic signed [31:0]                       operand_r;

	wire         setup_ph;
	wire         access_ph;
	wire         wr_en;
	wire         addr_ok;
	wire [31:0]  rd_mux;
	wire signed [31:0] wr_val;
	wire         diff_mode;
	wire signed [31:0] sx;
	wire signed [31:0] sy;
	wire signed [31:0] operand;
	wire signed [31:0] set_thr;
	wire signed [31:0] clr_thr;
	wire signed [31:0] on_blk;
	wire signed [31:0] off_blk;
	wire         hyst;
	wire         above_set;
	wire         at_or_below_clr;
	wire         in_window;

	scale_if sif_x ();
	scale_if sif_y ();

	// ************************************************************
	// input scaling, same gain and offset on both inputs
	// ************************************************************
	assign sif_x.raw    = first_analog_input_in;
	assign sif_x.gain   = gain_r;
	assign sif_x.offset = offset_r;
	assign sif_y.raw    = second_analog_input_in;
	assign sif_y.gain   = gain_r;
	assign sif_y.offset = offset_r;

	input_scaler u_scale_x (
		.mclk_in (mclk_in),
		.rstn_in (rstn_in),
		.sc      (sif_x.scaler)
	);

	input_scaler u_scale_y (
		.mclk_in (mclk_in),
		.rstn_in (rstn_in),
		.sc      (sif_y.scaler)
	);

	assign sx = sif_x.scaled;
	assign sy = sif_y.scaled;

	// ************************************************************
	// APB decode
	// ************************************************************
	assign setup_ph  = psel_in && !penable_in;
	assign access_ph = psel_in && penable_in;
	assign wr_en     = access_ph && pwrite_in && addr_ok;
	assign wr_val    = $signed(pwdata_in);
	assign addr_ok   = (paddr_in == thr_cmp_pkg::OFS_CTRL)     || (paddr_in == thr_cmp_pkg::OFS_GAIN)
	                || (paddr_in == thr_cmp_pkg::OFS_OFFSET)   || (paddr_in == thr_cmp_pkg::OFS_ON)
	                || (paddr_in == thr_cmp_pkg::OFS_OFF)      || (paddr_in == thr_cmp_pkg::OFS_BLKSEL)
	                || (paddr_in == thr_cmp_pkg::OFS_STATUS)   || (paddr_in == thr_cmp_pkg::OFS_OPERAND)
	                || (paddr_in == thr_cmp_pkg::OFS_SCALED_X) || (paddr_in == thr_cmp_pkg::OFS_SCALED_Y);
	assign rd_mux    = (paddr_in == thr_cmp_pkg::OFS_CTRL)     ? {27'h0000000, ctrl_r}
	                 : (paddr_in == thr_cmp_pkg::OFS_GAIN)     ? gain_r
	                 : (paddr_in == thr_cmp_pkg::OFS_OFFSET)   ? offset_r
	                 : (paddr_in == thr_cmp_pkg::OFS_ON)       ? on_r
	                 : (paddr_in == thr_cmp_pkg::OFS_OFF)      ? off_r
	                 : (paddr_in == thr_cmp_pkg::OFS_BLKSEL)   ? {16'h0000, blksel_r}
	                 : (paddr_in == thr_cmp_pkg::OFS_STATUS)   ? {31'h00000000, q_r}
	                 : (paddr_in == thr_cmp_pkg::OFS_OPERAND)  ? operand_r
	                 : (paddr_in == thr_cmp_pkg::OFS_SCALED_X) ? sx
	                 : (paddr_in == thr_cmp_pkg::OFS_SCALED_Y) ? sy
	                 : 32'h0000_0000;

	// read data and error captured in setup, presented with zero wait states
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup_ph) begin
			prdata_r  <= pwrite_in ? 32'h0000_0000 : rd_mux;
			pslverr_r <= !addr_ok;
		end
	end

	assign prdata_out  = prdata_r;
	assign pready_out  = 1'b1;
	assign pslverr_out = access_ph && pslverr_r;

	// ************************************************************
	// configuration registers, gain, offset and threshold writes saturated to range
	// ************************************************************
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			ctrl_r   <= thr_cmp_pkg::CTRL_RST;
			gain_r   <= thr_cmp_pkg::GAIN_RST;
			offset_r <= thr_cmp_pkg::ZERO_32;
			on_r     <= thr_cmp_pkg::ZERO_32;
			off_r    <= thr_cmp_pkg::ZERO_32;
			blksel_r <= 16'h0000;
		end else if (wr_en) begin
			if (paddr_in == thr_cmp_pkg::OFS_CTRL)
				ctrl_r <= pwdata_in[thr_cmp_pkg::CTRL_W-1:0];
			if (paddr_in == thr_cmp_pkg::OFS_GAIN)
				gain_r <= thr_cmp_pkg::sat(wr_val, thr_cmp_pkg::GAIN_LIM);
			if (paddr_in == thr_cmp_pkg::OFS_OFFSET)
				offset_r <= thr_cmp_pkg::sat(wr_val, thr_cmp_pkg::OFFSET_LIM);
			if (paddr_in == thr_cmp_pkg::OFS_ON)
				on_r <= thr_cmp_pkg::sat(wr_val, thr_cmp_pkg::THR_LIM);
			if (paddr_in == thr_cmp_pkg::OFS_OFF)
				off_r <= thr_cmp_pkg::sat(wr_val, thr_cmp_pkg::THR_LIM);
			if (paddr_in == thr_cmp_pkg::OFS_BLKSEL)
				blksel_r <= pwdata_in[2*thr_cmp_pkg::BLK_SEL_W-1:0];
		end
	end

	// ************************************************************
	// operand and thresholds
	// ************************************************************
	// decimal field is stored for readback only and reaches no comparison
	assign diff_mode = ctrl_r[thr_cmp_pkg::CTRL_MODE] == thr_cmp_pkg::MODE_DIFF;
	assign operand   = diff_mode ? (sx - sy) : sx;
	assign on_blk    = blk_pick(block_values_in, blksel_r[thr_cmp_pkg::BLK_SEL_W-1:0]);
	assign off_blk   = blk_pick(block_values_in, blksel_r[thr_cmp_pkg::SEL_OFF_LO +: thr_cmp_pkg::BLK_SEL_W]);
	assign set_thr   = (diff_mode && ctrl_r[thr_cmp_pkg::CTRL_ON_BLK]) ? on_blk : on_r;
	// single mode: off register holds the signed delta
	assign clr_thr   = !diff_mode ? (on_r + off_r)
	                 : (ctrl_r[thr_cmp_pkg::CTRL_OFF_BLK] ? off_blk : off_r);

	// ************************************************************
	// switching decision
	// ************************************************************
	// set >= clear covers a negative delta and the difference hysteresis case
	assign hyst            = set_thr >= clr_thr;
	assign above_set       = operand > set_thr;
	assign at_or_below_clr = operand <= clr_thr;
	assign in_window       = (operand >= set_thr) && (operand < clr_thr);

	always_comb begin
		if (hyst) begin
			if (above_set)
				q_nxt = 1'b1;
			else if (at_or_below_clr)
				q_nxt = 1'b0;
			else
				q_nxt = q_r;
		end else begin
			q_nxt = in_window;
		end
	end

	// one evaluation per program cycle; 32-bit math cannot overflow here
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			q_r       <= 1'b0;
			operand_r <= thr_cmp_pkg::ZERO_32;
		end else if (cycle_tick_in) begin
			q_r       <= q_nxt;
			operand_r <= operand;
		end
	end

	// output may be on-delayed downstream to reject short pulses
	assign switch_out       = q_r;
	assign actual_value_out = operand_r;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	a_gain_range: assert property (gain_r <= thr_cmp_pkg::GAIN_LIM && gain_r >= -thr_cmp_pkg::GAIN_LIM)
		else $error("gain outside range");
	a_offset_range: assert property ($changed(offset_r) |-> offset_r <= thr_cmp_pkg::OFFSET_LIM
		&& offset_r >= -thr_cmp_pkg::OFFSET_LIM)
		else $error("offset outside range");
	a_thr_range: assert property (on_r <= thr_cmp_pkg::THR_LIM && on_r >= -thr_cmp_pkg::THR_LIM
		&& off_r <= thr_cmp_pkg::THR_LIM && off_r >= -thr_cmp_pkg::THR_LIM)
		else $error("threshold outside range");
	a_auto_clear: assert property (!diff_mode && cycle_tick_in |=>
		switch_out == ($past(on_r + off_r) <= $past(on_r) ? $past(q_nxt) : $past(in_window)))
		else $error("clear threshold not derived from set plus delta");
	a_diff_operand: assert property (diff_mode && cycle_tick_in |=> actual_value_out == $past(sx - sy))
		else $error("difference operand wrong");
	a_hyst_set: assert property (cycle_tick_in && hyst && above_set |=> switch_out)
		else $error("output not set above set threshold");
	a_hyst_clear: assert property (cycle_tick_in && hyst && at_or_below_clr && !above_set |=> !switch_out)
		else $error("output not cleared at clear threshold");
	a_window_test: assert property (cycle_tick_in && !hyst |=>
		switch_out == ($past(operand) >= $past(set_thr) && $past(operand) < $past(clr_thr)))
		else $error("window output wrong");
	a_band_hold: assert property (cycle_tick_in && hyst && !above_set && !at_or_below_clr |=> $stable(switch_out))
		else $error("output changed inside hysteresis band");
	a_tick_only: assert property (!cycle_tick_in |=> $stable(switch_out) && $stable(actual_value_out))
		else $error("output changed without program cycle");
	a_block_set: assert property (diff_mode && ctrl_r[thr_cmp_pkg::CTRL_ON_BLK] |-> set_thr == on_blk)
		else $error("set threshold not taken from selected block");
endmodule : thr_comparator

// ---- core/thr_cmp_pkg.sv ----
// constants, register map and helpers for the analog threshold comparator
package thr_cmp_pkg;
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam int          RAW_W        = 10;
	localparam int          BLK_SEL_W    = 8;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_GAIN     = 8'h04;
	localparam logic [7:0]  OFS_OFFSET   = 8'h08;
	localparam logic [7:0]  OFS_ON       = 8'h0C;
	localparam logic [7:0]  OFS_OFF      = 8'h10;
	localparam logic [7:0]  OFS_BLKSEL   = 8'h14;
	localparam logic [7:0]  OFS_STATUS   = 8'h18;
	localparam logic [7:0]  OFS_OPERAND  = 8'h1C;
	localparam logic [7:0]  OFS_SCALED_X = 8'h20;
	localparam logic [7:0]  OFS_SCALED_Y = 8'h24;
	// ************************************************************
	// control field positions and reset values
	// ************************************************************
	localparam int          CTRL_MODE    = 0;
	localparam int          CTRL_DEC_LO  = 1;
	localparam int          CTRL_DEC_HI  = 2;
	localparam int          CTRL_ON_BLK  = 3;
	localparam int          CTRL_OFF_BLK = 4;
	localparam int          CTRL_W       = 5;
	localparam int          SEL_OFF_LO   = 8;
	localparam logic [4:0]  CTRL_RST     = 5'h00;
	localparam logic signed [31:0] GAIN_RST = 32'sh0000_0064;
	localparam logic signed [31:0] ZERO_32  = 32'sh0000_0000;
	// ************************************************************
	// ranges and scaling
	// ************************************************************
	localparam logic [RAW_W-1:0]   RAW_MAX    = 10'h3E8;
	localparam logic signed [31:0] GAIN_LIM   = 32'sh0000_03E8;
	localparam logic signed [31:0] OFFSET_LIM = 32'sh0000_2710;
	localparam logic signed [31:0] THR_LIM    = 32'sh0000_4E20;
	localparam logic signed [31:0] GAIN_DIV   = 32'sh0000_0064;

	typedef enum logic [0:0] {
		MODE_SINGLE = 1'b0,
		MODE_DIFF   = 1'b1
	} mode_t;

	// saturate a written value into plus/minus lim
	function automatic logic signed [31:0] sat(input logic signed [31:0] v, input logic signed [31:0] lim);
		if (v > lim)
			return lim;
		else if (v < -lim)
			return -lim;
		else
			return v;
	endfunction : sat
endpackage : thr_cmp_pkg

// ---- core/scale_if.sv ----
// carrier between the comparator and one input scaler
`timescale 1ns/1ps
interface scale_if;
	logic        [thr_cmp_pkg::RAW_W-1:0] raw;
	logic signed [31:0]                   gain;
	logic signed [31:0]                   offset;
	logic signed [31:0]                   scaled;
	modport src    (output raw, output gain, output offset, input scaled);
	modport scaler (input raw, input gain, input offset, output scaled);
endinterface : scale_if

// ---- core/input_scaler.sv ----
// one analog input: clamp to the internal range, multiply by gain, add offset
`timescale 1ns/1ps
module input_scaler (
	input  wire logic mclk_in,
	input  wire logic rstn_in,
	scale_if.scaler   sc
);
	logic        [thr_cmp_pkg::RAW_W-1:0] raw_lim;
	logic signed [31:0]                   product;
	logic signed [31:0]                   scaled_nxt;
	logic signed [31:0]                   scaled_r;

	// ************************************************************
	// datapath
	// ************************************************************
	assign raw_lim    = (sc.raw > thr_cmp_pkg::RAW_MAX) ? thr_cmp_pkg::RAW_MAX : sc.raw;
	assign product    = $signed({22'h000000, raw_lim}) * sc.gain;
	// gain is in hundredths; division truncates toward zero
	assign scaled_nxt = (product / thr_cmp_pkg::GAIN_DIV) + sc.offset;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			scaled_r <= thr_cmp_pkg::ZERO_32;
		else
			scaled_r <= scaled_nxt;
	end

	assign sc.scaled = scaled_r;

	// ************************************************************
	// checks
	// ************************************************************
	a_raw_range: assert property (@(posedge mclk_in) disable iff (!rstn_in) raw_lim <= thr_cmp_pkg::RAW_MAX)
		else $error("raw value above internal full scale");
	a_scale_track: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		$past(rstn_in) && $stable(sc.raw) && $stable(sc.gain) && $stable(sc.offset) |-> scaled_r == scaled_nxt)
		else $error("scaled value does not follow stable inputs");
endmodule : input_scaler

// ---- dv/analog_source.sv ----
// far-side model: analog input channels and live values of other function blocks
`timescale 1ns/1ps
module analog_source #(
	parameter int NBLK = 8
) (
	input  wire logic                             mclk_in,
	output logic      [thr_cmp_pkg::RAW_W-1:0]    first_out,
	output logic      [thr_cmp_pkg::RAW_W-1:0]    second_out,
	output logic      [NBLK*32-1:0]               blocks_out
);
	initial begin
		first_out = 10'h000;
		second_out = 10'h000;
		blocks_out = '0;
	end
	// channels refresh only right after a clock edge
	task automatic put(input logic [9:0] x, input logic [9:0] y);
		@(posedge mclk_in);
		first_out <= x;
		second_out <= y;
	endtask : put
	task automatic put_block(input int k, input logic signed [31:0] v);
		@(posedge mclk_in);
		blocks_out[k*32 +: 32] <= v;
	endtask : put_block
endmodule : analog_source

// ---- dv/tb_analog_threshold_comparator.sv ----
// self-checking bench for the threshold comparator with shadow model and result queue
`timescale 1ns/1ps
module tb_analog_threshold_comparator;
	localparam int NBLK = 8;
	typedef struct {string nm; logic [31:0] v;} note_t;
	logic mclk_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, cycle_tick_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out;
	logic pready_out, pslverr_out, switch_out;
	logic [31:0] actual_value_out;
	logic [9:0] x_w, y_w, xc = 10'h000, yc = 10'h000;
	logic [NBLK*32-1:0] blk_w;
	logic [4:0] ctrl = 5'h00;
	logic [15:0] bsel = 16'h0000;
	logic signed [31:0] gain = 32'sh64, ofs = 0, on_v = 0, off_v = 0, opv = 0, bv[NBLK];
	logic q = 1'b0;
	int n_fail = 0, n_compared = 0;
	note_t nq[$];
	// ************************************************************
	// design and far side
	// ************************************************************
	thr_comparator #(.NBLK(NBLK)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.cycle_tick_in(cycle_tick_in), .first_analog_input_in(x_w), .second_analog_input_in(y_w),
		.block_values_in(blk_w), .switch_out(switch_out), .actual_value_out(actual_value_out));
	analog_source #(.NBLK(NBLK)) src (.mclk_in(mclk_in), .first_out(x_w), .second_out(y_w), .blocks_out(blk_w));
	initial begin
		forever #2.5 mclk_in = ~mclk_in;
	end
	// ************************************************************
	// checking
	// ************************************************************
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic pop(input logic [31:0] seen);
		note_t e;
		if (nq.size() == 0) begin
			n_fail++;
			$display("mismatch unexpected result seen %h", seen);
		end else begin
			e = nq.pop_front();
			check(e.nm, seen, e.v);
		end
	endtask : pop
	always @(posedge mclk_in) begin
		if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1) begin
			pop(prdata_out);
			pop({31'h0, pslverr_out});
		end
		if (cycle_tick_in) begin
			#1;
			// a downstream on-delay would filter this output; the raw output is checked here
			pop({31'h0, switch_out});
			pop(actual_value_out);
		end
	end
	initial begin
		repeat (100000) @(posedge mclk_in);
		n_fail++;
		complete_run();
	end
	// ************************************************************
	// shadow model
	// ************************************************************
	function automatic logic signed [31:0] clip(input logic signed [31:0] v, input logic signed [31:0] l);
		return (v > l) ? l : (v < -l) ? -l : v;
	endfunction : clip
	function automatic logic signed [31:0] scl(input logic [9:0] r);
		logic signed [31:0] rr;
		rr = (r > 10'h3E8) ? 32'sh3E8 : {22'h0, r};
		return (rr * gain) / 32'sh64 + ofs;
	endfunction : scl
	function automatic logic signed [31:0] blk(input logic [7:0] k);
		return (k < NBLK) ? bv[k] : 32'sh0;
	endfunction : blk
	function automatic logic [31:0] exp_reg(input logic [7:0] a);
		case (a)
			thr_cmp_pkg::OFS_CTRL:     return {27'h0, ctrl};
			thr_cmp_pkg::OFS_GAIN:     return gain;
			thr_cmp_pkg::OFS_OFFSET:   return ofs;
			thr_cmp_pkg::OFS_ON:       return on_v;
			thr_cmp_pkg::OFS_OFF:      return off_v;
			thr_cmp_pkg::OFS_BLKSEL:   return {16'h0, bsel};
			thr_cmp_pkg::OFS_STATUS:   return {31'h0, q};
			thr_cmp_pkg::OFS_OPERAND:  return opv;
			thr_cmp_pkg::OFS_SCALED_X: return scl(xc);
			thr_cmp_pkg::OFS_SCALED_Y: return scl(yc);
			default:                   return 32'h0;
		endcase
	endfunction : exp_reg
	// ************************************************************
	// drivers
	// ************************************************************
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge mclk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			complete_run();
		end
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic signed [31:0] d);
		bus(a, 1'b1, d);
		case (a)
			thr_cmp_pkg::OFS_CTRL:   ctrl = d[4:0];
			thr_cmp_pkg::OFS_GAIN:   gain = clip(d, 32'sh3E8);
			thr_cmp_pkg::OFS_OFFSET: ofs = clip(d, 32'sh2710);
			thr_cmp_pkg::OFS_ON:     on_v = clip(d, 32'sh4E20);
			thr_cmp_pkg::OFS_OFF:    off_v = clip(d, 32'sh4E20);
			thr_cmp_pkg::OFS_BLKSEL: bsel = d[15:0];
			default: ;
		endcase
	endtask : wr
	task automatic rd(input logic [7:0] a);
		nq.push_back('{$sformatf("reg %h", a), exp_reg(a)});
		nq.push_back('{$sformatf("err %h", a), {31'h0, (a > 8'h24) || (a[1:0] != 2'b00)}});
		bus(a, 1'b0, 32'h0);
	endtask : rd
	task automatic ev(input logic [9:0] x, input logic [9:0] y);
		logic signed [31:0] st, cl;
		src.put(x, y);
		xc = x;
		yc = y;
		repeat (3) @(posedge mclk_in);
		opv = ctrl[0] ? scl(x) - scl(y) : scl(x);
		st = (ctrl[0] && ctrl[3]) ? blk(bsel[7:0]) : on_v;
		cl = !ctrl[0] ? on_v + off_v : ctrl[4] ? blk(bsel[15:8]) : off_v;
		if (st >= cl)
			q = (opv > st) ? 1'b1 : (opv <= cl) ? 1'b0 : q;
		else
			q = (opv >= st) && (opv < cl);
		cycle_tick_in <= 1'b1;
		nq.push_back('{"switch", {31'h0, q}});
		nq.push_back('{"actual", opv});
		@(posedge mclk_in);
		cycle_tick_in <= 1'b0;
	endtask : ev
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		void'($urandom(32'h1A81D9C9));
		foreach (bv[k]) bv[k] = 0;
		repeat (16) @(posedge mclk_in);
		check("switch in reset", {31'h0, switch_out}, 32'h0);
		rstn_in <= 1'b1;
		for (int a = 0; a <= 8'h2C; a += 4) rd(a[7:0]);
		rd(8'h3C);
		wr(thr_cmp_pkg::OFS_GAIN, 32'sh1388);
		wr(thr_cmp_pkg::OFS_OFFSET, -32'sh4E20);
		wr(thr_cmp_pkg::OFS_ON, 32'sh7530);
		wr(thr_cmp_pkg::OFS_OFF, -32'sh7530);
		wr(thr_cmp_pkg::OFS_STATUS, 32'h1);
		for (int a = 4; a <= 8'h18; a += 4) rd(a[7:0]);
		wr(thr_cmp_pkg::OFS_GAIN, 32'sh64);
		wr(thr_cmp_pkg::OFS_OFFSET, 0);
		wr(thr_cmp_pkg::OFS_ON, 32'sh1F4);
		wr(thr_cmp_pkg::OFS_OFF, -32'shC8);
		for (int i = 0; i < 6; i++) ev(i == 5 ? 10'd1000 : i == 4 ? 10'd501 : i == 2 ? 10'd300 : i == 0 ? 10'd600 : 10'd400, 0);
		wr(thr_cmp_pkg::OFS_OFF, 32'shC8);
		for (int i = 0; i < 5; i++) ev(10'd499 + (i == 1 ? 1 : i == 2 ? 200 : i == 3 ? 201 : i == 4 ? 524 : 0), 0);
		wr(thr_cmp_pkg::OFS_CTRL, 32'h6);
		wr(thr_cmp_pkg::OFS_GAIN, -32'sh96);
		wr(thr_cmp_pkg::OFS_OFFSET, 32'sh32);
		ev(10'd333, 0);
		for (int k = 0; k < NBLK; k++) begin
			bv[k] = $urandom_range(0, 3000) - 1500;
			src.put_block(k, bv[k]);
		end
		for (int c = 0; c < 60; c++) begin
			wr(thr_cmp_pkg::OFS_CTRL, $urandom_range(0, 31));
			wr(thr_cmp_pkg::OFS_GAIN, $urandom_range(0, 600) - 300);
			wr(thr_cmp_pkg::OFS_OFFSET, $urandom_range(0, 1000) - 500);
			wr(thr_cmp_pkg::OFS_ON, $urandom_range(0, 3000) - 1500);
			wr(thr_cmp_pkg::OFS_OFF, $urandom_range(0, 3000) - 1500);
			wr(thr_cmp_pkg::OFS_BLKSEL, {$urandom_range(0, 9), 8'h00} | $urandom_range(0, 9));
			for (int i = 0; i < 3; i++) ev($urandom_range(0, 1023), $urandom_range(0, 1023));
			for (int a = 0; a <= 8'h24; a += 4) rd(a[7:0]);
		end
		repeat (4) @(posedge mclk_in);
		complete_run();
	end
endmodule : tb_analog_threshold_comparator
